// ### rtl/qsr_map.svh
`ifndef QSR_MAP_SVH
`define QSR_MAP_SVH

// Register indices on the two-wire bus
`define QSR_REG_THR0 4'h0
`define QSR_REG_THR1 4'h1
`define QSR_REG_THR2 4'h2
`define QSR_REG_THR3 4'h3
`define QSR_REG_SRC 4'h4
`define QSR_REG_POL 4'h5
`define QSR_REG_TIME 4'h6
`define QSR_REG_LOCK 4'h7
`define QSR_REG_CAUSE 4'h8
`define QSR_REG_LAST 4'h8

// Reset values
`define QSR_THR_RST 8'h00
`define QSR_SRC_RST 8'h00
`define QSR_POL_RST 4'h0
`define QSR_HOLD_SEL_RST 2'h0
`define QSR_WD_SEL_RST 3'h0
`define QSR_AS0_RST 1'h0

// Field positions
`define QSR_SRC_EN_MSB 7
`define QSR_SRC_EN_LSB 4
`define QSR_SRC_RANGE_MSB 3
`define QSR_SRC_RANGE_LSB 0
`define QSR_TIME_HOLD_MSB 6
`define QSR_TIME_HOLD_LSB 5
`define QSR_TIME_WD_MSB 2
`define QSR_TIME_WD_LSB 0
`define QSR_LOCK_BIT 7
`define QSR_AS0_BIT 6
`define QSR_CAUSE_WD_BIT 0
`define QSR_CAUSE_MR_BIT 1

// Device type codes selected by the address select bit
`define QSR_TYPE_AS0_0 4'hA
`define QSR_TYPE_AS0_1 4'hB

// Threshold scale in millivolts
`define QSR_LOW_BASE_MV 13'h0258
`define QSR_LOW_STEP_MV 13'h0005
`define QSR_HIGH_BASE_MV 13'h0708
`define QSR_HIGH_STEP_MV 13'h000F

// Timebase: one tick per millisecond, clock period in nanoseconds
`define QSR_TICK_NS 1000000
`define QSR_CLK_NS 25
`define QSR_TICK_CYCLES (`QSR_TICK_NS / `QSR_CLK_NS)

// Hold times in milliseconds
`define QSR_HOLD_25 13'h0019
`define QSR_HOLD_50 13'h0032
`define QSR_HOLD_100 13'h0064
`define QSR_HOLD_200 13'h00C8

// Watchdog periods in milliseconds
`define QSR_WD_400 13'h0190
`define QSR_WD_800 13'h0320
`define QSR_WD_1600 13'h0640
`define QSR_WD_3200 13'h0C80
`define QSR_WD_6400 13'h1900

`endif

// ### rtl/qsr_pkg.sv
package qsr_pkg;
	typedef logic [12:0] qsr_mv_type;
	typedef logic [12:0] qsr_ms_type;
	typedef enum logic [1:0] {
		QSR_WD_OFF = 2'b00,
		QSR_WD_RUN = 2'b01,
		QSR_WD_WAIT = 2'b10
	} qsr_wd_state_type;
endpackage

// ### rtl/qsr_supervisor.sv
`timescale 1ns/1ps
`include "qsr_map.svh"

module qsr_supervisor #(
	parameter int TICK_CYCLES = `QSR_TICK_CYCLES,
	parameter logic [1:0] REVISION = 2'h1
) (
	input wire logic clk, // 40 MHz clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic manual_reset_n, // Manual reset pin, active low
	input wire logic watchdog_kick_in, // Watchdog kick pin
	input wire logic bus_select_pin_low, // Address strap, low bit
	input wire logic bus_select_pin_high, // Address strap, high bit
	input wire logic [3:0] above_threshold, // Comparator outputs, 1 when input above setpoint
	output qsr_pkg::qsr_mv_type threshold_mv [4], // Setpoint per channel in mV
	output logic [3:0] range_high, // Range per channel to comparators
	input wire logic [6:0] reg_dev_addr, // Device address from bus engine
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [3:0] reg_addr, // Register index
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, valid cycle after strobe
	output logic reg_ack, // Access accepted this cycle
	output logic [3:0] reset_out, // Open-drain reset drive level
	output logic [3:0] reset_oe // Open-drain enable, high pulls low
);
	import qsr_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);

	// Pin synchronisers
	logic [7:0] sync1;
	logic [7:0] sync2;
	logic kick_d;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1 <= 8'hFF;
			sync2 <= 8'hFF;
		end else begin
			sync1 <= {manual_reset_n, watchdog_kick_in, bus_select_pin_high, bus_select_pin_low,
				above_threshold};
			sync2 <= sync1;
		end
	end
	// Starts at the pull-up level so that no false kick follows reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			kick_d <= 1'b1;
		else
			kick_d <= sync2[6];
	end
	wire mr_low = ~sync2[7];
	wire kick_rise = sync2[6] & ~kick_d;
	wire [1:0] sel_pins = sync2[5:4];
	wire [3:0] above_s = sync2[3:0];

	// Millisecond tick
	// Hold and watchdog counters advance only on this one-cycle pulse
	logic [TW-1:0] tick_cnt;
	wire tick = (tick_cnt == TW'(TICK_CYCLES - 1));
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tick_cnt <= '0;
		else
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
	end

	// Configuration registers
	logic [7:0] thr [4];
	logic [7:0] src;
	logic [3:0] pol;
	logic [1:0] hold_sel;
	logic [2:0] wd_sel;
	logic lock;
	logic as0;
	logic [1:0] cause;

	wire [3:0] dev_type = as0 ? `QSR_TYPE_AS0_1 : `QSR_TYPE_AS0_0;
	wire selected = (reg_dev_addr[6:3] == dev_type) && (reg_dev_addr[2:1] == sel_pins);
	// Registers open only while manual reset is held low
	wire access_ok = selected & mr_low;
	wire wr_go = reg_wr & access_ok & ~lock;
	wire rd_go = reg_rd & access_ok;
	assign reg_ack = wr_go | rd_go;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++)
				thr[i] <= `QSR_THR_RST;
		end else if (wr_go && reg_addr <= `QSR_REG_THR3) begin
			thr[reg_addr[1:0]] <= reg_wdata;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src <= `QSR_SRC_RST;
			pol <= `QSR_POL_RST;
			hold_sel <= `QSR_HOLD_SEL_RST;
			wd_sel <= `QSR_WD_SEL_RST;
			lock <= 1'b0;
			as0 <= `QSR_AS0_RST;
		end else if (wr_go) begin
			if (reg_addr == `QSR_REG_SRC)
				src <= reg_wdata;
			if (reg_addr == `QSR_REG_POL)
				pol <= reg_wdata[3:0];
			if (reg_addr == `QSR_REG_TIME) begin
				hold_sel <= reg_wdata[`QSR_TIME_HOLD_MSB:`QSR_TIME_HOLD_LSB];
				wd_sel <= reg_wdata[`QSR_TIME_WD_MSB:`QSR_TIME_WD_LSB];
			end
			if (reg_addr == `QSR_REG_LOCK) begin
				lock <= reg_wdata[`QSR_LOCK_BIT];
				as0 <= reg_wdata[`QSR_AS0_BIT];
			end
		end
	end

	// Comparators stay live; the enable only gates the reset path
	wire [3:0] trig_en = src[`QSR_SRC_EN_MSB:`QSR_SRC_EN_LSB];
	assign range_high = src[`QSR_SRC_RANGE_MSB:`QSR_SRC_RANGE_LSB];

	// Setpoints and fault detection
	logic [3:0] fault;
	for (genvar g = 0; g < 4; g++) begin : g_chan
		wire [12:0] code = {5'h00, thr[g]};
		wire [12:0] low_mv = 13'(`QSR_LOW_BASE_MV + code * `QSR_LOW_STEP_MV);
		wire [12:0] high_mv = 13'(`QSR_HIGH_BASE_MV + code * `QSR_HIGH_STEP_MV);
		assign threshold_mv[g] = range_high[g] ? high_mv : low_mv;
		assign fault[g] = pol[g] ? above_s[g] : ~above_s[g];
	end

	// Hold time in ticks
	wire [12:0] hold_ticks = (hold_sel == 2'h0) ? `QSR_HOLD_25 :
		(hold_sel == 2'h1) ? `QSR_HOLD_50 :
		(hold_sel == 2'h2) ? `QSR_HOLD_100 : `QSR_HOLD_200;

	// Watchdog period; unlisted codes behave as off
	wire [12:0] wd_ticks = (wd_sel == 3'h3) ? `QSR_WD_400 :
		(wd_sel == 3'h4) ? `QSR_WD_800 :
		(wd_sel == 3'h5) ? `QSR_WD_1600 :
		(wd_sel == 3'h6) ? `QSR_WD_3200 :
		(wd_sel == 3'h7) ? `QSR_WD_6400 : 13'h0000;
	wire wd_enabled = (wd_ticks != 13'h0000);

	// Watchdog
	qsr_wd_state_type wd_state;
	qsr_wd_state_type next_wd_state;
	logic [12:0] wd_cnt;
	logic [12:0] next_wd_cnt;
	logic wd_fire;
	wire any_out = |reset_oe;

	always_comb begin
		next_wd_state = wd_state;
		next_wd_cnt = wd_cnt;
		wd_fire = 1'b0;
		case (wd_state)
			QSR_WD_OFF: begin
				next_wd_cnt = 13'h0000;
				if (wd_enabled)
					next_wd_state = QSR_WD_RUN;
			end
			QSR_WD_RUN: begin
				if (!wd_enabled) begin
					next_wd_state = QSR_WD_OFF;
					next_wd_cnt = 13'h0000;
				end else if (kick_rise) begin
					next_wd_cnt = 13'h0000;
				end else if (tick) begin
					if (wd_cnt + 13'h0001 >= wd_ticks) begin
						wd_fire = 1'b1;
						next_wd_state = QSR_WD_WAIT;
						next_wd_cnt = 13'h0000;
					end else begin
						next_wd_cnt = wd_cnt + 13'h0001;
					end
				end
			end
			QSR_WD_WAIT: begin
				next_wd_cnt = 13'h0000;
				if (!any_out)
					next_wd_state = wd_enabled ? QSR_WD_RUN : QSR_WD_OFF;
			end
			default: begin
				next_wd_state = QSR_WD_OFF;
				next_wd_cnt = 13'h0000;
			end
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wd_state <= QSR_WD_OFF;
			wd_cnt <= 13'h0000;
		end else begin
			wd_state <= next_wd_state;
			wd_cnt <= next_wd_cnt;
		end
	end

	// Reset cause flags; a new event wins over a clear in the same cycle
	wire cause_clr = wr_go && (reg_addr == `QSR_REG_CAUSE);
	wire [1:0] cause_set = {mr_low, wd_fire};
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cause <= 2'h0;
		else
			cause <= (cause & ~(cause_clr ? reg_wdata[1:0] : 2'h0)) | cause_set;
	end

	// Reset outputs with hold stretch; power-up starts with the default hold
	// Reload on every cause cycle, so the hold is timed from the cause's end
	logic [12:0] hold_cnt [4];
	logic [3:0] chan_cause;
	for (genvar g = 0; g < 4; g++) begin : g_out
		assign chan_cause[g] = mr_low | wd_fire | (trig_en[g] & fault[g]);
		always_ff @(posedge clk or posedge rst) begin
			if (rst)
				hold_cnt[g] <= `QSR_HOLD_25;
			else if (chan_cause[g])
				hold_cnt[g] <= hold_ticks;
			else if (tick && hold_cnt[g] != 13'h0000)
				hold_cnt[g] <= hold_cnt[g] - 13'h0001;
		end
		assign reset_oe[g] = chan_cause[g] | (hold_cnt[g] != 13'h0000);
	end
	assign reset_out = 4'h0;

	// Register read data
	wire [7:0] rd_word [9];
	assign rd_word[0] = thr[0];
	assign rd_word[1] = thr[1];
	assign rd_word[2] = thr[2];
	assign rd_word[3] = thr[3];
	assign rd_word[4] = src;
	assign rd_word[5] = {fault, pol};
	assign rd_word[6] = {1'b1, hold_sel, REVISION, wd_sel};
	assign rd_word[7] = {lock, as0, 6'h00};
	assign rd_word[8] = {6'h00, cause};
	// Read data stands until the next accepted read
	wire [7:0] next_rdata = (reg_addr <= `QSR_REG_LAST) ? rd_word[reg_addr] : 8'h00;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (rd_go)
			reg_rdata <= next_rdata;
	end

	// Checks
	sequence s_kick_run;
		kick_rise && wd_state == QSR_WD_RUN && wd_enabled;
	endsequence
	sequence s_mr_release;
		$rose(sync2[7]);
	endsequence
	sequence s_fault_end;
		trig_en[1] && fault[1] ##1 !chan_cause[1];
	endsequence

	a_mr_all_low: assert property (@(posedge clk) disable iff (rst)
		mr_low |-> reset_oe == 4'hF) else $error("Manual reset did not assert all outputs");
	a_mr_no_bypass: assert property (@(posedge clk) disable iff (rst)
		mr_low |=> hold_cnt[0] == $past(hold_ticks)) else $error("Manual reset did not load hold");
	a_mr_hold_after: assert property (@(posedge clk) disable iff (rst)
		s_mr_release |-> reset_oe == 4'hF && hold_cnt[3] == hold_ticks) else $error("Hold missing after release");
	a_hold_decode: assert property (@(posedge clk) disable iff (rst)
		hold_sel == 2'h2 |-> hold_ticks == 13'h0064) else $error("Hold code 10 not 100 ms");
	a_fault_asserts: assert property (@(posedge clk) disable iff (rst)
		((trig_en & fault) & ~reset_oe) == 4'h0) else $error("Enabled fault without reset");
	a_fault_stretch: assert property (@(posedge clk) disable iff (rst)
		$fell(chan_cause[1]) |-> reset_oe[1] && hold_cnt[1] != 13'h0000) else $error("Fault end not stretched");
	a_kick_clear: assert property (@(posedge clk) disable iff (rst)
		s_kick_run |=> wd_cnt == 13'h0000) else $error("Kick did not clear watchdog");
	a_wd_all_low: assert property (@(posedge clk) disable iff (rst)
		wd_fire |-> reset_oe == 4'hF ##1 wd_state == QSR_WD_WAIT) else $error("Watchdog expiry not applied");
	a_wd_cause_flag: assert property (@(posedge clk) disable iff (rst)
		wd_fire |=> cause[0]) else $error("Watchdog cause not recorded");
	a_wd_restart: assert property (@(posedge clk) disable iff (rst)
		wd_state == QSR_WD_WAIT && !any_out && wd_enabled |=> wd_state == QSR_WD_RUN && wd_cnt == 13'h0000)
		else $error("Watchdog did not restart on release");
	a_wd_off_quiet: assert property (@(posedge clk) disable iff (rst)
		wd_sel == 3'h0 |-> !wd_fire) else $error("Watchdog fired while off");
	a_status_live: assert property (@(posedge clk) disable iff (rst)
		rd_go && reg_addr == `QSR_REG_POL |=> reg_rdata[7:4] == $past(fault)) else $error("Status nibble wrong");
	a_open_drain: assert property (@(posedge clk) disable iff (rst)
		reset_out == 4'h0) else $error("Reset pin driven high");
	a_addr_match: assert property (@(posedge clk) disable iff (rst)
		reg_ack |-> reg_dev_addr[2:1] == sel_pins) else $error("Answered wrong address");
	a_thr_scale: assert property (@(posedge clk) disable iff (rst)
		thr[1] == 8'hFF && range_high[1] |-> threshold_mv[1] == 13'h15F9) else $error("Top setpoint wrong");

	// Register updates, hold countdown and watchdog details
	a_kick_level: assert property (@(posedge clk) disable iff (rst)
		wd_state == QSR_WD_RUN && wd_enabled && !kick_rise && tick && (wd_cnt + 13'h0001 < wd_ticks)
		|=> wd_cnt == $past(wd_cnt) + 13'h0001) else $error("Steady kick level restarted watchdog");
	a_access_gate: assert property (@(posedge clk) disable iff (rst)
		reg_ack |-> mr_low && selected) else $error("Access taken without manual reset low");
	a_wd_wait_hold: assert property (@(posedge clk) disable iff (rst)
		wd_state == QSR_WD_WAIT && any_out |=> wd_state == QSR_WD_WAIT && wd_cnt == 13'h0000)
		else $error("Watchdog left wait early");
	a_hold_countdown: assert property (@(posedge clk) disable iff (rst)
		!chan_cause[0] && tick && hold_cnt[0] != 13'h0000 |=> hold_cnt[0] == $past(hold_cnt[0]) - 13'h0001)
		else $error("Hold counter did not step down");
	a_thr_write: assert property (@(posedge clk) disable iff (rst)
		wr_go && reg_addr == `QSR_REG_THR0 |=> thr[0] == $past(reg_wdata)) else $error("Threshold write lost");
	a_trig_gate: assert property (@(posedge clk) disable iff (rst)
		!trig_en[2] && !mr_low && !wd_fire && hold_cnt[2] == 13'h0000 |-> !reset_oe[2])
		else $error("Disabled channel asserted its reset");
	a_fault_release: assert property (@(posedge clk) disable iff (rst)
		s_fault_end |-> reset_oe[1] && hold_cnt[1] == $past(hold_ticks)) else $error("Fault end hold not loaded");
	a_pol_write: assert property (@(posedge clk) disable iff (rst)
		wr_go && reg_addr == `QSR_REG_POL |=> pol == $past(reg_wdata[3:0])) else $error("Polarity write lost");
	a_hold_sel_write: assert property (@(posedge clk) disable iff (rst)
		wr_go && reg_addr == `QSR_REG_TIME |=> hold_sel == $past(reg_wdata[`QSR_TIME_HOLD_MSB:`QSR_TIME_HOLD_LSB]))
		else $error("Hold select write lost");
	a_wd_period_top: assert property (@(posedge clk) disable iff (rst)
		wd_sel == 3'h7 |-> wd_ticks == 13'h1900) else $error("Longest watchdog period wrong");
	a_wd_disable: assert property (@(posedge clk) disable iff (rst)
		!wd_enabled && wd_state == QSR_WD_RUN |=> wd_state == QSR_WD_OFF) else $error("Watchdog ran while off");
endmodule // qsr_supervisor

// ### verif/qsr_host_model.sv
`timescale 1ns/1ps
module qsr_host_model (
	input logic kick_en, // Kicks run while high
	input qsr_pkg::qsr_mv_type vin_mv [4], // Supply levels in mV
	input qsr_pkg::qsr_mv_type threshold_mv [4], // Setpoints from the device
	output logic [3:0] above_threshold, // Comparator results
	output logic watchdog_kick_in // Kick pin
);
	import qsr_pkg::*;
	for (genvar i = 0; i < 4; i++) begin : g_cmp
		assign above_threshold[i] = vin_mv[i] > threshold_mv[i];
	end
	// Kick runs at 200 ns off the core clock phase; idle level is the pull-up
	initial begin
		watchdog_kick_in = 1'b1;
		#7;
		forever begin
			#100;
			watchdog_kick_in = kick_en ? ~watchdog_kick_in : 1'b1;
		end
	end
endmodule // qsr_host_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import qsr_pkg::*;
	localparam int TK = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mr_n = 1'b1;
	logic kick_en = 1'b0;
	logic kick;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [6:0] dev = 7'h54;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic ack;
	logic quiet;
	logic [3:0] above;
	logic [3:0] rng;
	logic [3:0] rout;
	logic [3:0] roe;
	qsr_mv_type thr [4];
	qsr_mv_type vin [4] = '{13'h0FFF, 13'h0FFF, 13'h0FFF, 13'h0FFF};
	logic [7:0] tv [4] = '{8'h00, 8'hFF, 8'h06, 8'hFF};
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	qsr_supervisor #(.TICK_CYCLES(TK)) DUT (
		.clk(clk), .rst(rst), .manual_reset_n(mr_n), .watchdog_kick_in(kick),
		.bus_select_pin_low(1'b0), .bus_select_pin_high(1'b1), .above_threshold(above),
		.threshold_mv(thr), .range_high(rng), .reg_dev_addr(dev), .reg_wr(wr), .reg_rd(rd),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack),
		.reset_out(rout), .reset_oe(roe)
	);
	qsr_host_model host (.kick_en(kick_en), .vin_mv(vin), .threshold_mv(thr),
		.above_threshold(above), .watchdog_kick_in(kick));
	always #12.5 clk = ~clk;
	task automatic results;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			results();
		end
	end
	task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic ok);
		@(negedge clk);
		wr = w;
		rd = ~w;
		addr = a;
		wdata = d;
		#1;
		chk("ack", 16'(ack), 16'(ok));
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00, 1'b1);
		chk("rdata", 16'(rdata), 16'(e));
	endtask
	task automatic wait_oe(input logic [3:0] v);
		n = 0;
		while (roe !== v && n < 4000) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic in_rng(input string s, input int lo, input int hi);
		chk(s, 16'(n >= lo && n <= hi), 16'h0001);
	endtask
	task automatic quiet_for(input int c);
		quiet = 1'b1;
		repeat (c) begin
			@(negedge clk);
			quiet &= (roe === 4'h0);
		end
	endtask
	task automatic mr_low;
		mr_n = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	function automatic logic [15:0] mv(input logic [7:0] c, input logic h);
		return h ? 16'h0708 + 16'(c) * 16'h000F : 16'h0258 + 16'(c) * 16'h0005;
	endfunction
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("oe_powerup", 16'(roe), 16'h000F);
		chk("out_level", 16'(rout), 16'h0000);
		acc(1'b1, 4'h0, 8'h55, 1'b0);
		mr_low();
		chk("oe_manual", 16'(roe), 16'h000F);
		dev = 7'h56;
		acc(1'b1, 4'h0, 8'h55, 1'b0);
		dev = 7'h54;
		for (int i = 0; i < 4; i++) acc(1'b1, 4'(i), tv[i], 1'b1);
		acc(1'b1, 4'h4, 8'h02, 1'b1);
		for (int i = 0; i < 4; i++) begin
			rdc(4'(i), tv[i]);
			chk("thr_mv", 16'(thr[i]), mv(tv[i], i == 1));
		end
		chk("range", 16'(rng), 16'h0002);
		rdc(4'h4, 8'h02);
		rdc(4'hF, 8'h00);
		for (int h = 0; h < 4; h++) begin
			acc(1'b1, 4'h6, 8'(h << 5), 1'b1);
			rdc(4'h6, 8'(h << 5) | 8'h88);
			mr_n = 1'b1;
			wait_oe(4'h0);
			in_rng("hold", (25 << h) * TK - TK, (25 << h) * TK + 4);
			mr_low();
		end
		acc(1'b1, 4'h6, 8'h00, 1'b1);
		acc(1'b1, 4'h4, 8'h30, 1'b1);
		acc(1'b1, 4'h5, 8'h02, 1'b1);
		vin = '{13'h03E8, 13'h07D0, 13'h0000, 13'h0FFF};
		repeat (4) @(negedge clk);
		rdc(4'h5, 8'h62);
		mr_n = 1'b1;
		wait_oe(4'h2);
		chk("oe_over", 16'(roe), 16'h0002);
		vin[1] = 13'h03E8;
		wait_oe(4'h0);
		in_rng("fault_hold", 24 * TK, 25 * TK + 4);
		vin[0] = 13'h01F4;
		repeat (4) @(negedge clk);
		chk("oe_under", 16'(roe), 16'h0001);
		vin[0] = 13'h03E8;
		wait_oe(4'h0);
		mr_low();
		chk("oe_manual2", 16'(roe), 16'h000F);
		acc(1'b1, 4'h6, 8'h03, 1'b1);
		kick_en = 1'b1;
		mr_n = 1'b1;
		wait_oe(4'h0);
		quiet_for(4800);
		chk("wd_kicked", 16'(quiet), 16'h0001);
		kick_en = 1'b0;
		wait_oe(4'hF);
		in_rng("wd_fire", 400 * TK - 12, 400 * TK + 12);
		wait_oe(4'h0);
		wait_oe(4'hF);
		in_rng("wd_rerun", 400 * TK - 8, 400 * TK + 8);
		mr_low();
		acc(1'b0, 4'h8, 8'h00, 1'b1);
		chk("wd_cause", 16'(rdata[0]), 16'h0001);
		acc(1'b1, 4'h6, 8'h00, 1'b1);
		acc(1'b1, 4'h8, 8'h01, 1'b1);
		mr_n = 1'b1;
		wait_oe(4'h0);
		quiet_for(2000);
		chk("wd_off", 16'(quiet), 16'h0001);
		mr_low();
		acc(1'b0, 4'h8, 8'h00, 1'b1);
		chk("wd_cause_off", 16'(rdata[0]), 16'h0000);
		results();
	end
endmodule // tb_top
